// ---- dsc_map.svh ----
`ifndef DSC_MAP_SVH
`define DSC_MAP_SVH
// *********************************
// strap-selected 7-bit addresses, lowest ratio first
// *********************************
`define DSC_ID0 7'h2c
`define DSC_ID1 7'h2e
`define DSC_ID2 7'h30
`define DSC_ID3 7'h32
`define DSC_ID4 7'h34
`define DSC_ID5 7'h36
`define DSC_ID6 7'h38
`define DSC_ID7 7'h3c
// *********************************
// field positions and reset values
// *********************************
`define DSC_RW_BIT 0
`define DSC_PTR_RST 8'h00
// *********************************
// timing
// *********************************
`define DSC_CLK_NS 5
`define DSC_PX_QTR_NS 625
`define DSC_PX_QTR_CYC ((`DSC_PX_QTR_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`define DSC_PX_IDLE_NS 5000
`define DSC_PX_IDLE_CYC ((`DSC_PX_IDLE_NS + `DSC_CLK_NS - 1) / `DSC_CLK_NS)
`endif

// ---- dsc_pkg.sv ----
package dsc_pkg;
    // gray codes along the usual path
    typedef enum logic [2:0] {
        SL_IDLE = 3'h0,
        SL_ADDR = 3'h1,
        SL_AACK = 3'h3,
        SL_WDATA = 3'h2,
        SL_WACK = 3'h6,
        SL_RDATA = 3'h7,
        SL_RACK = 3'h5
    } dsc_sl_state_t;

    typedef enum logic [2:0] {
        PX_IDLE = 3'h0,
        PX_START = 3'h1,
        PX_BIT = 3'h3,
        PX_STOP = 3'h2,
        PX_WAIT = 3'h6
    } dsc_px_state_t;

    typedef struct packed {
        logic we;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dsc_reg_req_t;
endpackage : dsc_pkg

// ---- dsc_proxy.sv ----
`timescale 1ns/1ps
`include "dsc_map.svh"
module dsc_proxy #(
    parameter int QTR_CYC = `DSC_PX_QTR_CYC,
    parameter int IDLE_CYC = `DSC_PX_IDLE_CYC
) (
    input wire logic mclk, // system clock
    input wire logic rst_q_n, // synchronised reset
    input wire logic px_req, // start a one-byte transfer
    input wire logic [7:0] px_byte, // byte to send
    output logic px_busy, // transfer in progress
    output logic px_done, // transfer finished pulse
    output logic px_nack, // far slave did not acknowledge
    output logic px_lost, // arbitration lost pulse
    input wire logic m_scl_i, // channel clock level
    output logic m_scl_o, // channel clock out, always low
    output logic m_scl_oe, // pull channel clock low
    input wire logic m_sda_i, // channel data level
    output logic m_sda_o, // channel data out, always low
    output logic m_sda_oe // pull channel data low
);
    if (QTR_CYC < 2 || QTR_CYC > 65535 || IDLE_CYC < 1 || IDLE_CYC > 65535) begin : g_bad_timing
        $error("dsc_proxy: timing parameter out of range");
    end

    dsc_pkg::dsc_px_state_t st_q;
    logic scl_m_q, scl_s_q, sda_m_q, sda_s_q;
    logic [15:0] div_q, idle_q;
    logic [1:0] ph_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q, byte_q;
    logic tick, adv, idle_ok;

    always_ff @(posedge mclk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            {scl_m_q, scl_s_q, sda_m_q, sda_s_q} <= 4'hf;
        end else begin
            scl_m_q <= m_scl_i;
            scl_s_q <= scl_m_q;
            sda_m_q <= m_sda_i;
            sda_s_q <= sda_m_q;
        end
    end

    // quarter-bit enable; idle time counts a free bus before any start
    assign tick = (div_q == 16'(QTR_CYC - 1));
    assign idle_ok = (idle_q == 16'(IDLE_CYC - 1));
    // hold while another device stretches the clock low
    assign adv = tick && !(!m_scl_oe && !scl_s_q);

    always_ff @(posedge mclk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            div_q <= 16'h0;
            idle_q <= 16'h0;
        end else begin
            div_q <= tick ? 16'h0 : div_q + 16'h1;
            if (!(scl_s_q && sda_s_q)) begin
                idle_q <= 16'h0;
            end else if (!idle_ok) begin
                idle_q <= idle_q + 16'h1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            st_q <= dsc_pkg::PX_IDLE;
            ph_q <= 2'h0;
            bit_q <= 4'h0;
            sh_q <= 8'h0;
            byte_q <= 8'h0;
            px_busy <= 1'b0;
            px_done <= 1'b0;
            px_nack <= 1'b0;
            px_lost <= 1'b0;
            m_scl_oe <= 1'b0;
            m_sda_oe <= 1'b0;
            m_scl_o <= 1'b0;
            m_sda_o <= 1'b0;
        end else begin
            px_done <= 1'b0;
            px_lost <= 1'b0;
            case (st_q)
                dsc_pkg::PX_IDLE: begin
                    if (px_req) begin
                        byte_q <= px_byte;
                        px_busy <= 1'b1;
                        st_q <= dsc_pkg::PX_WAIT;
                    end
                end
                dsc_pkg::PX_WAIT: begin
                    if (idle_ok && adv) begin // R10
                        sh_q <= byte_q;
                        ph_q <= 2'h0;
                        st_q <= dsc_pkg::PX_START;
                    end
                end
                dsc_pkg::PX_START: begin
                    if (adv) begin
                        ph_q <= ph_q + 2'h1;
                        if (ph_q == 2'h0) begin
                            m_sda_oe <= 1'b1;
                        end else if (ph_q == 2'h1) begin
                            m_scl_oe <= 1'b1;
                            bit_q <= 4'h0;
                            ph_q <= 2'h0;
                            st_q <= dsc_pkg::PX_BIT;
                        end
                    end
                end
                dsc_pkg::PX_BIT: begin
                    if (adv) begin
                        ph_q <= ph_q + 2'h1;
                        case (ph_q)
                            2'h0: m_sda_oe <= (bit_q < 4'h8) ? !sh_q[7] : 1'b0;
                            2'h1: m_scl_oe <= 1'b0;
                            2'h2: begin
                                if (bit_q < 4'h8 && sh_q[7] && !sda_s_q) begin // R10
                                    m_sda_oe <= 1'b0;
                                    m_scl_oe <= 1'b0;
                                    px_lost <= 1'b1;
                                    st_q <= dsc_pkg::PX_WAIT;
                                end else if (bit_q == 4'h8) begin
                                    px_nack <= sda_s_q;
                                end
                            end
                            default: begin
                                m_scl_oe <= 1'b1;
                                sh_q <= {sh_q[6:0], 1'b0};
                                bit_q <= bit_q + 4'h1;
                                if (bit_q == 4'h8) begin
                                    st_q <= dsc_pkg::PX_STOP;
                                end
                            end
                        endcase
                    end
                end
                dsc_pkg::PX_STOP: begin
                    if (adv) begin
                        ph_q <= ph_q + 2'h1;
                        case (ph_q)
                            2'h0: m_sda_oe <= 1'b1;
                            2'h1: m_scl_oe <= 1'b0;
                            2'h2: m_sda_oe <= 1'b0;
                            default: begin
                                px_done <= 1'b1;
                                px_busy <= 1'b0;
                                st_q <= dsc_pkg::PX_IDLE;
                            end
                        endcase
                    end
                end
                default: st_q <= dsc_pkg::PX_IDLE;
            endcase
        end
    end

    a_lost_release: assert property (@(posedge mclk) disable iff (!rst_q_n) // R10
        px_lost |-> !m_sda_oe && !m_scl_oe && st_q == dsc_pkg::PX_WAIT)
        else $error("proxy still drives after losing arbitration");
    a_retry_idle: assert property (@(posedge mclk) disable iff (!rst_q_n) // R10
        (st_q == dsc_pkg::PX_START && $past(st_q) == dsc_pkg::PX_WAIT) |-> $past(idle_ok))
        else $error("proxy retried on a busy bus");
endmodule : dsc_proxy

// ---- dsc_slave.sv ----
// Function
// R01: strap ratio picks one of eight addresses
// R02: scl input only, sda open drain
// R03: sda rising while scl high is stop
// R04: sda falling while scl high is start
// R05: ack own address, release otherwise
// R06: ack every received write byte
// R07: master nacks last read byte, then stop
// R08: transfers only between start and stop
// R09: local master tolerates clock stretching
// R10: proxy master backs off on lost bit
// R11: far master never reaches host slaves
// R12: masters hand over through mailbox register
// R13: no restart or stop during another's bit
// R14: arbitrate local and remote register accesses
// R15: older partner limits who reaches registers
// R16: same-register concurrent access stays correct
// R17: one channel direction active at once
// R18: override bit selects register address field
`timescale 1ns/1ps
`include "dsc_map.svh"
module dsc_slave #(
    parameter int PX_QTR_CYC = `DSC_PX_QTR_CYC,
    parameter int PX_IDLE_CYC = `DSC_PX_IDLE_CYC
) (
    input wire logic mclk, // 200 MHz system clock
    input wire logic rst_n, // async reset, active low
    input wire logic scl_i, // bus clock pin level
    input wire logic sda_i, // bus data pin level
    output logic sda_o, // bus data out, always low
    output logic sda_oe, // pull bus data low
    input wire logic [2:0] address_strap_pin, // digitised strap ratio, 0 lowest
    input wire logic address_override_select, // use ovr_addr instead of strap
    input wire logic [6:0] ovr_addr, // device-address field
    output logic reg_valid, // register access strobe
    output dsc_pkg::dsc_reg_req_t reg_req, // register access
    input wire logic [7:0] reg_rdata, // read data, sampled in the reg_valid cycle
    input wire logic rm_req, // remote access request, held until rm_gnt
    input wire dsc_pkg::dsc_reg_req_t rm_info, // remote access
    output logic rm_gnt, // remote access done pulse
    output logic [7:0] rm_rdata, // remote read data with rm_gnt
    input wire logic px_req, // proxy transfer request
    input wire logic [7:0] px_byte, // proxy byte
    output logic px_busy, // proxy busy
    output logic px_done, // proxy done pulse
    output logic px_nack, // proxy saw nack
    output logic px_lost, // proxy lost arbitration pulse
    input wire logic m_scl_i, // channel clock level
    output logic m_scl_o, // channel clock out
    output logic m_scl_oe, // channel clock pull low
    input wire logic m_sda_i, // channel data level
    output logic m_sda_o, // channel data out
    output logic m_sda_oe // channel data pull low
);
    // ******************************
    // reset and input synchronisers
    // ******************************
    logic rst_m_q, rst_q_n, strap_done_q, scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
    logic [2:0] strap_m_q, strap_s_q, strap_idx_q;
    logic [6:0] own_addr_q;

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            rst_m_q <= 1'b0;
            rst_q_n <= 1'b0;
        end else begin
            rst_m_q <= 1'b1;
            rst_q_n <= rst_m_q;
        end
    end

    always_ff @(posedge mclk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            {scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q} <= 6'h3f;
        end else begin
            scl_m_q <= scl_i; // R02
            scl_s_q <= scl_m_q;
            scl_p_q <= scl_s_q;
            sda_m_q <= sda_i;
            sda_s_q <= sda_m_q;
            sda_p_q <= sda_s_q;
        end
    end

    always_ff @(posedge mclk) begin
        strap_m_q <= address_strap_pin; // R01
        strap_s_q <= strap_m_q;
    end

    // ******************************
    // own address
    // ******************************
    localparam logic [6:0] STRAP_ADDR [8] = '{`DSC_ID0, `DSC_ID1, `DSC_ID2, `DSC_ID3,
        `DSC_ID4, `DSC_ID5, `DSC_ID6, `DSC_ID7};

    // strap caught once, after the synchroniser has filled
    always_ff @(posedge mclk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            strap_done_q <= 1'b0;
            strap_idx_q <= 3'h0;
            own_addr_q <= `DSC_ID0;
        end else begin
            if (!strap_done_q && scl_p_q == scl_s_q) begin
                strap_idx_q <= strap_s_q; // R01
                strap_done_q <= 1'b1;
            end
            own_addr_q <= address_override_select ? ovr_addr : STRAP_ADDR[strap_idx_q]; // R18
        end
    end

    // ******************************
    // bus protocol
    // ******************************
    logic scl_rise, scl_fall, start_det, stop_det, byte_end;
    logic [7:0] rx_byte;
    dsc_pkg::dsc_sl_state_t st_q;
    logic [3:0] bit_q;
    logic [7:0] sh_q, tx_q, rdbuf_q, ptr_q;
    logic rd_q, first_q, wr_ev, rd_ev;

    assign scl_rise = scl_s_q && !scl_p_q;
    assign scl_fall = !scl_s_q && scl_p_q;
    assign start_det = scl_s_q && scl_p_q && sda_p_q && !sda_s_q; // R04
    assign stop_det = scl_s_q && scl_p_q && !sda_p_q && sda_s_q; // R03
    assign rx_byte = {sh_q[6:0], sda_s_q};
    assign byte_end = scl_rise && bit_q == 4'h7;
    assign wr_ev = st_q == dsc_pkg::SL_WDATA && byte_end;
    assign rd_ev = (st_q == dsc_pkg::SL_ADDR && byte_end && rx_byte[`DSC_RW_BIT]
                    && rx_byte[7:1] == own_addr_q)
                   || (st_q == dsc_pkg::SL_RACK && scl_rise && !sda_s_q);

    always_ff @(posedge mclk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            st_q <= dsc_pkg::SL_IDLE;
            bit_q <= 4'h0;
            sh_q <= 8'h0;
            tx_q <= 8'h0;
            rd_q <= 1'b0;
            sda_oe <= 1'b0;
            sda_o <= 1'b0;
        end else if (stop_det) begin
            st_q <= dsc_pkg::SL_IDLE; // R03 R08
            sda_oe <= 1'b0;
        end else if (start_det) begin
            st_q <= dsc_pkg::SL_ADDR; // R04 R08
            bit_q <= 4'h0;
            sda_oe <= 1'b0;
        end else begin
            case (st_q)
                dsc_pkg::SL_ADDR, dsc_pkg::SL_WDATA: begin
                    if (scl_rise && bit_q < 4'h8) begin
                        sh_q <= rx_byte;
                        bit_q <= bit_q + 4'h1;
                        if (st_q == dsc_pkg::SL_ADDR && bit_q == 4'h7) begin
                            rd_q <= rx_byte[`DSC_RW_BIT];
                        end
                    end
                    if (scl_fall && bit_q == 4'h8) begin
                        if (st_q == dsc_pkg::SL_WDATA) begin
                            st_q <= dsc_pkg::SL_WACK;
                            sda_oe <= 1'b1; // R06
                        end else if (sh_q[7:1] == own_addr_q) begin
                            st_q <= dsc_pkg::SL_AACK;
                            sda_oe <= 1'b1; // R05
                        end else begin
                            st_q <= dsc_pkg::SL_IDLE; // R05
                        end
                    end
                end
                dsc_pkg::SL_AACK, dsc_pkg::SL_WACK: begin
                    if (scl_fall) begin
                        bit_q <= 4'h0;
                        if (st_q == dsc_pkg::SL_AACK && rd_q) begin
                            st_q <= dsc_pkg::SL_RDATA;
                            tx_q <= {rdbuf_q[6:0], 1'b0};
                            sda_oe <= !rdbuf_q[7];
                        end else begin
                            st_q <= dsc_pkg::SL_WDATA;
                            sda_oe <= 1'b0;
                        end
                    end
                end
                dsc_pkg::SL_RDATA: begin
                    if (scl_fall) begin
                        bit_q <= bit_q + 4'h1;
                        tx_q <= {tx_q[6:0], 1'b0};
                        sda_oe <= (bit_q == 4'h7) ? 1'b0 : !tx_q[7];
                        if (bit_q == 4'h7) begin
                            st_q <= dsc_pkg::SL_RACK;
                        end
                    end
                end
                dsc_pkg::SL_RACK: begin
                    if (scl_rise && sda_s_q) begin
                        st_q <= dsc_pkg::SL_IDLE; // R07
                    end else if (scl_fall) begin
                        bit_q <= 4'h0;
                        st_q <= dsc_pkg::SL_RDATA;
                        tx_q <= {rdbuf_q[6:0], 1'b0};
                        sda_oe <= !rdbuf_q[7];
                    end
                end
                default: sda_oe <= 1'b0;
            endcase
        end
    end

    // ******************************
    // register access and arbitration
    // ******************************
    // one access in flight at a time, round robin between local and remote;
    // a scl bit lasts far longer than the worst wait, so the read is ready in time
    logic loc_pend_q, busy_q, own_rm_q, last_rm_q, take_rm, take_loc;
    dsc_pkg::dsc_reg_req_t loc_q;

    assign take_rm = !busy_q && rm_req && !rm_gnt && (!loc_pend_q || !last_rm_q);
    assign take_loc = !busy_q && loc_pend_q && !take_rm;

    always_ff @(posedge mclk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            first_q <= 1'b1;
            ptr_q <= `DSC_PTR_RST;
            loc_pend_q <= 1'b0;
            loc_q <= '0;
        end else begin
            if (take_loc) begin
                loc_pend_q <= 1'b0;
            end
            if (start_det) begin
                first_q <= 1'b1;
            end else if (wr_ev && first_q) begin
                ptr_q <= rx_byte;
                first_q <= 1'b0;
            end else if (wr_ev || rd_ev) begin
                loc_q <= '{we: wr_ev, addr: ptr_q, wdata: rx_byte};
                loc_pend_q <= 1'b1;
                ptr_q <= ptr_q + 8'h1;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_q_n) begin
        if (!rst_q_n) begin
            busy_q <= 1'b0;
            own_rm_q <= 1'b0;
            last_rm_q <= 1'b0;
            reg_valid <= 1'b0;
            reg_req <= '0;
            rm_gnt <= 1'b0;
            rm_rdata <= 8'h0;
            rdbuf_q <= 8'h0;
        end else begin
            rm_gnt <= 1'b0;
            reg_valid <= take_rm || take_loc; // R14 R16
            busy_q <= take_rm || take_loc;
            if (take_rm || take_loc) begin
                reg_req <= take_rm ? rm_info : loc_q;
                own_rm_q <= take_rm;
                last_rm_q <= take_rm;
            end
            if (busy_q && own_rm_q) begin
                rm_gnt <= 1'b1;
                rm_rdata <= reg_rdata;
            end else if (busy_q && !reg_req.we) begin
                rdbuf_q <= reg_rdata;
            end
        end
    end

    // ******************************
    // proxy master of the control channel
    // ******************************
    dsc_proxy #(.QTR_CYC(PX_QTR_CYC), .IDLE_CYC(PX_IDLE_CYC)) u_proxy (.mclk(mclk), .rst_q_n(rst_q_n),
        .px_req(px_req), .px_byte(px_byte), .px_busy(px_busy), .px_done(px_done), .px_nack(px_nack),
        .px_lost(px_lost), .m_scl_i(m_scl_i), .m_scl_o(m_scl_o), .m_scl_oe(m_scl_oe), .m_sda_i(m_sda_i),
        .m_sda_o(m_sda_o), .m_sda_oe(m_sda_oe));

    // ******************************
    // checks
    // ******************************
    a_stop_idle: assert property (@(posedge mclk) disable iff (!rst_q_n) // R03
        stop_det |=> st_q == dsc_pkg::SL_IDLE && !sda_oe) else $error("stop not honoured");
    a_start_addr: assert property (@(posedge mclk) disable iff (!rst_q_n) // R04
        (start_det && !stop_det) |=> st_q == dsc_pkg::SL_ADDR && bit_q == 4'h0) else $error("start not honoured");
    a_idle_quiet: assert property (@(posedge mclk) disable iff (!rst_q_n) // R02 R08
        st_q == dsc_pkg::SL_IDLE |-> !sda_oe && !sda_o) else $error("data driven outside a frame");
    a_addr_ack: assert property (@(posedge mclk) disable iff (!rst_q_n) // R05
        (st_q == dsc_pkg::SL_ADDR && scl_fall && bit_q == 4'h8 && !start_det && !stop_det)
        |=> sda_oe == (sh_q[7:1] == $past(own_addr_q))) else $error("address ack wrong");
    a_write_ack: assert property (@(posedge mclk) disable iff (!rst_q_n) // R06
        $rose(st_q == dsc_pkg::SL_WACK) |-> sda_oe ##1 sda_oe) else $error("write byte not acked");
    a_own_addr: assert property (@(posedge mclk) disable iff (!rst_q_n) // R18
        ##1 $past(address_override_select) |-> own_addr_q == $past(ovr_addr)) else $error("override unused");
    a_remote_served: assert property (@(posedge mclk) disable iff (!rst_q_n) // R14
        (rm_req && !rm_gnt) |-> ##[1:5] rm_gnt) else $error("remote access starved");
    a_one_owner: assert property (@(posedge mclk) disable iff (!rst_q_n) // R16
        reg_valid |=> !reg_valid && $stable(reg_req)) else $error("overlapping register accesses");
endmodule : dsc_slave

// ---- dsc_host.sv ----
`timescale 1ns/1ps
// ****
// bus master seen by the slave
// ****
module dsc_host (
    input wire logic mclk, // system clock
    input wire logic sda_i, // bus data level
    output logic scl, // bus clock, driven by us only
    output logic sda_pull // pull bus data low
);
    localparam int H = 20;
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end
    task automatic hc();
        repeat (H) @(posedge mclk);
    endtask : hc
    task automatic start();
        sda_pull <= 1'b0;
        hc();
        scl <= 1'b1;
        hc();
        sda_pull <= 1'b1;
        hc();
        scl <= 1'b0;
        hc();
    endtask : start
    task automatic stop();
        sda_pull <= 1'b1;
        hc();
        scl <= 1'b1;
        hc();
        sda_pull <= 1'b0;
        hc();
    endtask : stop
    // data moves mid-low only, else the slave sees a false start or stop
    task automatic xbit(input logic b, output logic r);
        sda_pull <= !b;
        hc();
        scl <= 1'b1;
        hc();
        r = sda_i;
        scl <= 1'b0;
        hc();
    endtask : xbit
    // mack high releases the ninth bit, ending a read
    task automatic xbyte(input logic [7:0] tx, input logic mack, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            xbit(tx[i], rx[i]);
        end
        xbit(mack, ack);
    endtask : xbyte
endmodule : dsc_host

// ---- tb.sv ----
`timescale 1ns/1ps
module tb;
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic ovr_sel = 1'b0;
    logic rm_req = 1'b0;
    logic px_req = 1'b0;
    logic far_pull = 1'b0;
    logic [2:0] strap = 3'h0;
    logic [6:0] ovr_addr = 7'h00;
    logic [7:0] px_byte = 8'h00;
    dsc_pkg::dsc_reg_req_t rm_info = '0;
    dsc_pkg::dsc_reg_req_t reg_req;
    logic scl, pull, sda_o, sda_oe, m_scl_oe, m_sda_oe, reg_valid, rm_gnt, px_done, px_nack, px_lost, ack;
    logic [7:0] rm_rdata, rx, p, d;
    logic [7:0] mem [256];
    int err_count = 0;
    int samples_checked = 0;
    int seed = 9;
    wire logic sda = !(sda_oe | pull);
    wire logic m_sda = !(m_sda_oe | far_pull);
    dsc_host i_dsc_host (.mclk(mclk), .sda_i(sda), .scl(scl), .sda_pull(pull));
    dsc_slave #(.PX_QTR_CYC(4), .PX_IDLE_CYC(8)) i_dsc_slave (.mclk(mclk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda),
        .sda_o(sda_o), .sda_oe(sda_oe), .address_strap_pin(strap), .address_override_select(ovr_sel),
        .ovr_addr(ovr_addr), .reg_valid(reg_valid), .reg_req(reg_req), .reg_rdata(mem[reg_req.addr]),
        .rm_req(rm_req), .rm_info(rm_info), .rm_gnt(rm_gnt), .rm_rdata(rm_rdata), .px_req(px_req),
        .px_byte(px_byte), .px_busy(), .px_done(px_done), .px_nack(px_nack), .px_lost(px_lost),
        .m_scl_i(!m_scl_oe), .m_scl_o(), .m_scl_oe(m_scl_oe), .m_sda_i(m_sda), .m_sda_o(), .m_sda_oe(m_sda_oe));
    initial begin
        forever #2.5 mclk = !mclk;
    end
    // register store, read side is combinational so data is ready in the reg_valid cycle
    always @(posedge mclk) if (reg_valid && reg_req.we) mem[reg_req.addr] <= reg_req.wdata;
    function automatic logic [6:0] strap_addr(input logic [2:0] s);
        return (s == 3'h7) ? 7'h3c : 7'h2c + {3'h0, s, 1'b0};
    endfunction : strap_addr
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : report_and_stop
    // looks at the negative edge so flop outputs are settled
    task automatic wait_on(input int sel);
        for (int i = 0; i < 5000; i++) begin
            @(negedge mclk);
            if (sel == 0 ? px_done : sel == 1 ? px_lost : sel == 2 ? rm_gnt : sel == 3 ? reg_valid :
                (m_scl_oe && !m_sda_oe)) begin
                @(posedge mclk);
                return;
            end
        end
        err_count++;
        $display("ERROR %0t: timeout", $time);
        report_and_stop();
    endtask : wait_on
    task automatic xb(input logic [7:0] tx, input logic mack);
        i_dsc_host.xbyte(tx, mack, rx, ack);
    endtask : xb
    task automatic probe(input logic [6:0] a, input logic exp);
        i_dsc_host.start();
        xb({a, 1'b0}, 1'b1);
        i_dsc_host.stop();
        chk({7'h0, ack}, {7'h0, exp});
    endtask : probe
    task automatic wr2(input logic [7:0] pt, input logic [7:0] v);
        i_dsc_host.start();
        xb({7'h3c, 1'b0}, 1'b1);
        xb(pt, 1'b1);
        xb(v, 1'b1);
        xb(~v, 1'b1);
        chk({7'h0, ack}, 8'h00);
        i_dsc_host.stop();
    endtask : wr2
    initial begin
        for (int s = 0; s < 8; s++) begin
            strap <= s[2:0];
            rst_n <= 1'b0;
            repeat (6) @(posedge mclk);
            rst_n <= 1'b1;
            repeat (8) @(posedge mclk);
            probe(strap_addr(s[2:0]) ^ 7'h01, 1'b1);
            probe(strap_addr(s[2:0]), 1'b0);
        end
        chk({7'h0, sda_o}, 8'h00);
        // clock a byte with no start in front: must be ignored
        i_dsc_host.xbit(1'b1, ack);
        xb({7'h3c, 1'b0}, 1'b1);
        chk({7'h0, ack}, 8'h01);
        i_dsc_host.stop();
        $display("address tests done");
        p = $random(seed);
        d = $random(seed);
        wr2(p, d);
        chk(mem[p], d);
        chk(mem[p + 8'h01], ~d);
        i_dsc_host.start();
        xb({7'h3c, 1'b0}, 1'b1);
        xb(p, 1'b1);
        i_dsc_host.start();
        xb({7'h3c, 1'b1}, 1'b1);
        xb(8'hff, 1'b0);
        chk(rx, d);
        xb(8'hff, 1'b1);
        chk(rx, ~d);
        chk({7'h0, sda_oe}, 8'h00);
        i_dsc_host.stop();
        ovr_addr <= {1'b1, 6'($random(seed))};
        ovr_sel <= 1'b1;
        @(posedge mclk);
        probe(ovr_addr, 1'b0);
        probe(7'h3c, 1'b1);
        ovr_sel <= 1'b0;
        $display("transfer tests done");
        // remote write issued in the cycle after a local write access completes; mailbox register
        fork
            wr2(8'h20, d);
            begin
                wait_on(3);
                rm_info <= '{we: 1'b1, addr: 8'h19, wdata: p};
                rm_req <= 1'b1;
                wait_on(2);
                rm_req <= 1'b0;
            end
        join
        chk(mem[8'h20], d);
        chk(mem[8'h21], ~d);
        rm_info <= '{we: 1'b0, addr: 8'h19, wdata: 8'h00};
        rm_req <= 1'b1;
        wait_on(2);
        rm_req <= 1'b0;
        chk(rm_rdata, p);
        $display("remote tests done");
        px_byte <= 8'hff;
        px_req <= 1'b1;
        @(posedge mclk);
        px_req <= 1'b0;
        wait_on(4);
        far_pull <= 1'b1;
        wait_on(1);
        chk({6'h0, m_sda_oe, m_scl_oe}, 8'h00);
        far_pull <= 1'b0;
        wait_on(0);
        chk({7'h0, px_nack}, 8'h01);
        $display("proxy tests done");
        report_and_stop();
    end
endmodule : tb
